// ---- design/icrb_config_bank.sv ----
/*
 * Indexed configuration register bank: index port and data port on the
 * host I/O bus, three configuration registers and their control outputs.
 * Assumes single-cycle, clock-synchronous I/O strobes and that the key
 * sequence logic outside supplies the configuration-mode level.
 */
// Behaviour
// - Host loads the index by writing the primary or alternate index port.
// - The data port reads and writes the register the index picks.
// - Index responds only in configuration mode; host writes it first.
// - The held index chooses the register a later data access reaches.
// - Registers load defaults at power-up; ordinary reset only sets the register one lock bit.
// - Register zero sits at index zero, configuration mode only, default 28H.
// - Register zero bits 1:0 pick alternate functions; 00 default, 01 reserved.
// - Codes 0x enable pull-ups on drive enable and both chip selects.
// - Code 11 routes extra interrupt and alternate IR pair, pull-ups off.
// - Code 10 drives the drive-interface pins, pull-ups off.
// - Register zero bit 3 powers the floppy controller; cleared means low power.
// - Register zero bit 2 reads 0, bit 5 reads 1, bits 4,6 read 0.
// - Register zero bit 7 is a software flag, cleared at power-up.
// - Register one sits at index one, configuration mode only, default 9CH.
// - Register one bits 0,1,5,6 read 0 and bit 4 reads 1.
// - Register one bit 2 powers the parallel port; cleared means low power.
// - Register one bit 3 selects printer mode; cleared enables extended modes.
// - Register one bit 7 unlocks the register group; only resets set it again.
// - Register two sits at index two, configuration mode only, default 88H.
// - Register two bit 3 runs the primary serial port; cleared powers down.
// - Register two bit 7 runs the secondary serial port; cleared powers down.
// - Register two bits 0-2 and 4-6 read as zero.
// - Power-down stops the unit but leaves its address decode in place.
`timescale 1ns/1ps
`default_nettype none

module icrb_config_bank
	import icrb_pkg::*;
(
	input  wire logic                        ref_clk_i,
	input  wire logic                        rst_b_i,
	input  wire logic                        por_b_i,
	input  wire logic                        config_mode_i,
	input  wire logic                        alt_base_i,
	input  wire logic [icrb_pkg::ICRB_AW-1:0] io_addr_i,
	input  wire logic                        io_wr_i,
	input  wire logic                        io_rd_i,
	input  wire logic [icrb_pkg::ICRB_DW-1:0] io_wdata_i,
	output logic      [icrb_pkg::ICRB_DW-1:0] io_rdata_o,
	output logic                             io_rvalid_o,
	output logic      [icrb_pkg::ICRB_DW-1:0] config_index_select_o,
	output logic                             floppy_power_on_o,
	output logic                             parallel_power_on_o,
	output logic                             printer_mode_o,
	output logic                             primary_serial_power_on_o,
	output logic                             secondary_serial_power_on_o,
	output logic                             config_valid_o,
	output logic                             config_write_lock_o,
	output logic                             drive_pullup_en_o,
	output logic                             drive_pins_oe_o,
	output logic                             alt_ir_en_o,
	output logic                             extra_irq_en_o
);
	import icrb_pkg::*;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [ICRB_DW-1:0]              idx;
		logic [ICRB_NREG-1:0][ICRB_DW-1:0] cr;
		logic [ICRB_DW-1:0]              rdata;
		logic                            rvalid;
	} icrb_state_t;

	icrb_state_t st_r;
	icrb_state_t st_nxt;

	// ------------------------------------------------------------------
	// Per-register tables
	// ------------------------------------------------------------------
	function automatic logic [ICRB_DW-1:0] cr_wmask(input int n);
		case (n)
			0:       cr_wmask = ICRB_ALTFN_WM;
			1:       cr_wmask = ICRB_PARPWR_WM;
			default: cr_wmask = ICRB_SERPWR_WM;
		endcase
	endfunction

	function automatic logic [ICRB_DW-1:0] cr_ones(input int n);
		case (n)
			0:       cr_ones = ICRB_ALTFN_ONE;
			1:       cr_ones = ICRB_PARPWR_ONE;
			default: cr_ones = ICRB_SERPWR_ONE;
		endcase
	endfunction

	function automatic logic [ICRB_DW-1:0] cr_default(input int n);
		case (n)
			0:       cr_default = ICRB_ALTFN_RST;
			1:       cr_default = ICRB_PARPWR_RST;
			default: cr_default = ICRB_SERPWR_RST;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// Port decode
	// ------------------------------------------------------------------
	logic idx_hit;
	logic dat_hit;
	logic unlocked;
	logic in_group;
	logic idx_wr;
	logic dat_wr;
	logic dat_rd;

	assign idx_hit  = io_addr_i == (alt_base_i ? ICRB_IDX_ALT : ICRB_IDX_PRI);
	assign dat_hit  = io_addr_i == (alt_base_i ? ICRB_DAT_ALT : ICRB_DAT_PRI);
	assign unlocked = st_r.cr[1][ICRB_LOCK];
	// Lock covers the whole low group, not only the registers built here
	assign in_group = st_r.idx <= ICRB_IDX_LOCKMAX;
	// Nothing reaches the bank outside configuration mode
	assign idx_wr = config_mode_i && io_wr_i && idx_hit;
	assign dat_wr = config_mode_i && io_wr_i && dat_hit;
	assign dat_rd = config_mode_i && io_rd_i && dat_hit;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		st_nxt        = st_r;
		st_nxt.rvalid = dat_rd;
		st_nxt.rdata  = ICRB_RD_NONE;
		if (dat_rd && (unlocked || !in_group)) begin
			for (int n = 0; n < ICRB_NREG; n++) begin
				if (st_r.idx == ICRB_DW'(n)) begin
					st_nxt.rdata = (st_r.cr[n] & cr_wmask(n)) | cr_ones(n);
				end
			end
		end
		if (idx_wr) begin
			st_nxt.idx = io_wdata_i;
		end
		if (dat_wr && (unlocked || !in_group)) begin
			for (int n = 0; n < ICRB_NREG; n++) begin
				if (st_r.idx == ICRB_DW'(n)) begin
					st_nxt.cr[n] = io_wdata_i & cr_wmask(n);
				end
			end
			// Lock bit can be cleared by software but never set again
			st_nxt.cr[1][ICRB_LOCK] = unlocked & ((st_r.idx != ICRB_IDX_PARPWR)
				| io_wdata_i[ICRB_LOCK]);
		end
		if (!rst_b_i) begin
			// Hard reset sets the lock bit and clears the read answer; it leaves the index and the other register bits alone
			st_nxt.cr[1][ICRB_LOCK] = 1'b1;
			st_nxt.rvalid           = 1'b0;
			st_nxt.rdata            = ICRB_RD_NONE;
		end
		if (!por_b_i) begin
			st_nxt.idx    = ICRB_IDX_RST;
			st_nxt.rvalid = 1'b0;
			st_nxt.rdata  = ICRB_RD_NONE;
			for (int n = 0; n < ICRB_NREG; n++) begin
				st_nxt.cr[n] = cr_default(n);
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		st_r <= st_nxt;
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	logic [1:0] alt_code;

	assign alt_code = st_r.cr[0][ICRB_ALT_LSB +: 2];

	assign io_rdata_o            = st_r.rdata;
	assign io_rvalid_o           = st_r.rvalid;
	assign config_index_select_o = st_r.idx;
	// Power bits gate the unit only; base decode elsewhere stays live
	assign floppy_power_on_o           = st_r.cr[0][ICRB_FDC_PWR];
	assign parallel_power_on_o         = st_r.cr[1][ICRB_PAR_PWR];
	assign printer_mode_o              = st_r.cr[1][ICRB_PAR_PRN];
	assign primary_serial_power_on_o   = st_r.cr[2][ICRB_SER1_PWR];
	assign secondary_serial_power_on_o = st_r.cr[2][ICRB_SER2_PWR];
	// Flag for software only, steers nothing
	assign config_valid_o              = st_r.cr[0][ICRB_VALID];
	assign config_write_lock_o         = !unlocked;
	assign drive_pullup_en_o = !alt_code[1];
	assign drive_pins_oe_o   = alt_code == ICRB_ALT_DRIVE;
	assign alt_ir_en_o       = alt_code == ICRB_ALT_IR;
	assign extra_irq_en_o    = alt_code == ICRB_ALT_IR;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!por_b_i || !rst_b_i);
	// Reset lifts on the clock edge, so antecedents also exclude it
	logic live;

	assign live = rst_b_i && por_b_i;

	property p_idx_ignored;
		live && !config_mode_i |=> $stable(st_r.idx);
	endproperty
	a_idx_ignored: assert property (p_idx_ignored)
		else $error("index changed outside configuration mode");

	property p_cr_ignored;
		live && !config_mode_i |=> $stable(st_r.cr);
	endproperty
	a_cr_ignored: assert property (p_cr_ignored)
		else $error("register changed outside configuration mode");

	property p_idx_load;
		por_b_i && idx_wr |=> config_index_select_o == $past(io_wdata_i);
	endproperty
	a_idx_load: assert property (p_idx_load)
		else $error("index write not taken");

	property p_read_one_cycle;
		dat_rd |=> io_rvalid_o ##1 (io_rvalid_o == $past(dat_rd));
	endproperty
	a_read_one_cycle: assert property (p_read_one_cycle)
		else $error("read answer not one cycle later");

	property p_cr0_ro;
		dat_rd && unlocked && st_r.idx == ICRB_IDX_ALTFN
			|=> io_rdata_o[6:4] == 3'b010 && !io_rdata_o[2];
	endproperty
	a_cr0_ro: assert property (p_cr0_ro)
		else $error("register zero fixed bits wrong");

	property p_cr1_ro;
		dat_rd && unlocked && st_r.idx == ICRB_IDX_PARPWR
			|=> io_rdata_o[6:4] == 3'b001 && io_rdata_o[1:0] == 2'b00;
	endproperty
	a_cr1_ro: assert property (p_cr1_ro)
		else $error("register one fixed bits wrong");

	property p_cr2_write;
		live && dat_wr && unlocked && st_r.idx == ICRB_IDX_SERPWR
			|=> st_r.cr[2] == ($past(io_wdata_i) & ICRB_SERPWR_WM)
			&& primary_serial_power_on_o == $past(io_wdata_i[ICRB_SER1_PWR])
			&& secondary_serial_power_on_o == $past(io_wdata_i[ICRB_SER2_PWR]);
	endproperty
	a_cr2_write: assert property (p_cr2_write)
		else $error("register two write not taken");

	property p_cr2_ro;
		live && dat_rd && unlocked && st_r.idx == ICRB_IDX_SERPWR
			|=> io_rdata_o[6:4] == 3'b000 && io_rdata_o[2:0] == 3'b000;
	endproperty
	a_cr2_ro: assert property (p_cr2_ro)
		else $error("register two fixed bits wrong");

	property p_cr0_write;
		live && dat_wr && unlocked && st_r.idx == ICRB_IDX_ALTFN
			|=> floppy_power_on_o == $past(io_wdata_i[ICRB_FDC_PWR])
			&& config_valid_o == $past(io_wdata_i[ICRB_VALID]);
	endproperty
	a_cr0_write: assert property (p_cr0_write)
		else $error("register zero write not taken");

	property p_cr1_write;
		live && dat_wr && unlocked && st_r.idx == ICRB_IDX_PARPWR
			|=> parallel_power_on_o == $past(io_wdata_i[ICRB_PAR_PWR])
			&& printer_mode_o == $past(io_wdata_i[ICRB_PAR_PRN]);
	endproperty
	a_cr1_write: assert property (p_cr1_write)
		else $error("register one write not taken");

	property p_lock_sticky;
		live && config_write_lock_o |=> config_write_lock_o [*2];
	endproperty
	a_lock_sticky: assert property (p_lock_sticky)
		else $error("lock released without reset");

	property p_locked_read;
		dat_rd && !unlocked && in_group |=> io_rdata_o == ICRB_RD_NONE;
	endproperty
	a_locked_read: assert property (p_locked_read)
		else $error("locked register readable");

	property p_locked_write;
		live && dat_wr && !unlocked && in_group |=> $stable(st_r.cr);
	endproperty
	a_locked_write: assert property (p_locked_write)
		else $error("locked register written");

	property p_unbuilt_read;
		live && dat_rd && st_r.idx > ICRB_IDX_SERPWR |=> io_rdata_o == ICRB_RD_NONE;
	endproperty
	a_unbuilt_read: assert property (p_unbuilt_read)
		else $error("unbuilt index read not zero");

	property p_unbuilt_write;
		live && dat_wr && st_r.idx > ICRB_IDX_SERPWR |=> $stable(st_r.cr);
	endproperty
	a_unbuilt_write: assert property (p_unbuilt_write)
		else $error("unbuilt index write reached a register");

	property p_pins;
		drive_pullup_en_o != (drive_pins_oe_o || alt_ir_en_o);
	endproperty
	a_pins: assert property (p_pins)
		else $error("pull-up state conflicts with pin use");

	property p_alt_off;
		!alt_code[1] |-> !drive_pins_oe_o && !alt_ir_en_o && !extra_irq_en_o;
	endproperty
	a_alt_off: assert property (p_alt_off)
		else $error("alternate function enabled for code 0x");

	property p_no_stray;
		!dat_rd |=> !io_rvalid_o;
	endproperty
	a_no_stray: assert property (p_no_stray)
		else $error("read answer without data-port read");

	property p_por_defaults;
		@(posedge ref_clk_i) disable iff (1'b0)
		!por_b_i |=> st_r.cr[0] == ICRB_ALTFN_RST && st_r.cr[1] == ICRB_PARPWR_RST
			&& st_r.cr[2] == ICRB_SERPWR_RST;
	endproperty
	a_por_defaults: assert property (p_por_defaults)
		else $error("power-up defaults not loaded");

	property p_rst_keeps;
		@(posedge ref_clk_i) disable iff (!por_b_i)
		por_b_i && !rst_b_i |=> st_r.cr[2] == $past(st_r.cr[2]) && unlocked;
	endproperty
	a_rst_keeps: assert property (p_rst_keeps)
		else $error("hard reset disturbed register or lock");

	property p_por_index;
		@(posedge ref_clk_i) disable iff (1'b0)
		!por_b_i |=> config_index_select_o == ICRB_IDX_RST && !io_rvalid_o
			&& !config_valid_o;
	endproperty
	a_por_index: assert property (p_por_index)
		else $error("power-up index or flag wrong");

	c_idx_write: cover property (idx_wr);
	c_cr0_read: cover property (dat_rd && st_r.idx == ICRB_IDX_ALTFN);
	c_lock_clear: cover property (unlocked ##1 !unlocked);
	c_alt_ir: cover property (alt_ir_en_o);
	c_alt_drive: cover property (drive_pins_oe_o);

endmodule

`default_nettype wire

// ---- design/icrb_pkg.sv ----
/*
 * Constants for the indexed configuration register bank: I/O port
 * addresses, register indices, reset values, field positions and masks.
 * Assumes 10-bit ISA I/O decoding on the host side.
 */
package icrb_pkg;

	// ------------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------------
	localparam int          ICRB_AW          = 10;
	localparam int          ICRB_DW          = 8;
	localparam int          ICRB_NREG        = 3;

	// ------------------------------------------------------------------
	// Host I/O ports
	// ------------------------------------------------------------------
	localparam logic [9:0]  ICRB_IDX_PRI     = 10'h3F0;
	localparam logic [9:0]  ICRB_DAT_PRI     = 10'h3F1;
	localparam logic [9:0]  ICRB_IDX_ALT     = 10'h370;
	localparam logic [9:0]  ICRB_DAT_ALT     = 10'h371;

	// ------------------------------------------------------------------
	// Register indices
	// ------------------------------------------------------------------
	localparam logic [7:0]  ICRB_IDX_ALTFN   = 8'h00;
	localparam logic [7:0]  ICRB_IDX_PARPWR  = 8'h01;
	localparam logic [7:0]  ICRB_IDX_SERPWR  = 8'h02;
	localparam logic [7:0]  ICRB_IDX_LOCKMAX = 8'h18;

	// ------------------------------------------------------------------
	// Power-up values, writable masks, read-only ones
	// ------------------------------------------------------------------
	localparam logic [7:0]  ICRB_ALTFN_RST   = 8'h28;
	localparam logic [7:0]  ICRB_PARPWR_RST  = 8'h9C;
	localparam logic [7:0]  ICRB_SERPWR_RST  = 8'h88;
	localparam logic [7:0]  ICRB_IDX_RST     = 8'h00;
	localparam logic [7:0]  ICRB_ALTFN_WM    = 8'h8B;
	localparam logic [7:0]  ICRB_PARPWR_WM   = 8'h8C;
	localparam logic [7:0]  ICRB_SERPWR_WM   = 8'h88;
	localparam logic [7:0]  ICRB_ALTFN_ONE   = 8'h20;
	localparam logic [7:0]  ICRB_PARPWR_ONE  = 8'h10;
	localparam logic [7:0]  ICRB_SERPWR_ONE  = 8'h00;
	localparam logic [7:0]  ICRB_RD_NONE     = 8'h00;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int          ICRB_ALT_LSB     = 0;
	localparam int          ICRB_FDC_PWR     = 3;
	localparam int          ICRB_VALID       = 7;
	localparam int          ICRB_PAR_PWR     = 2;
	localparam int          ICRB_PAR_PRN     = 3;
	localparam int          ICRB_LOCK        = 7;
	localparam int          ICRB_SER1_PWR    = 3;
	localparam int          ICRB_SER2_PWR    = 7;

	// Alternate function codes
	localparam logic [1:0]  ICRB_ALT_DRIVE   = 2'b10;
	localparam logic [1:0]  ICRB_ALT_IR      = 2'b11;

endpackage

// ---- testbench/icrb_host_model.sv ----
/*
 * Host model: issues single I/O write and read cycles on the index
 * and data ports of the configuration register bank.
 * Assumes the bench calls its tasks one at a time.
 */
`timescale 1ns/1ps
`default_nettype none

module icrb_host_model (
	input  wire logic                         ref_clk_i,
	input  wire logic [icrb_pkg::ICRB_DW-1:0] io_rdata_i,
	input  wire logic                         io_rvalid_i,
	output logic      [icrb_pkg::ICRB_AW-1:0] io_addr_o,
	output logic                              io_wr_o,
	output logic                              io_rd_o,
	output logic      [icrb_pkg::ICRB_DW-1:0] io_wdata_o
);
	import icrb_pkg::*;

	initial begin
		io_addr_o  = '0;
		io_wr_o    = 1'b0;
		io_rd_o    = 1'b0;
		io_wdata_o = '0;
	end

	// ------------------------------------------------------------------
	// Bus cycles
	// ------------------------------------------------------------------
	// After release the bus shows the inverse, so stale values never match
	task automatic io_write(input logic [9:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		io_addr_o  <= a;
		io_wdata_o <= d;
		io_wr_o    <= 1'b1;
		@(posedge ref_clk_i);
		io_wr_o    <= 1'b0;
		io_addr_o  <= ~a;
		io_wdata_o <= ~d;
		#1;
	endtask

	task automatic io_read(input logic [9:0] a, output logic [7:0] d, output logic v);
		@(posedge ref_clk_i);
		io_addr_o <= a;
		io_rd_o   <= 1'b1;
		@(posedge ref_clk_i);
		io_rd_o   <= 1'b0;
		io_addr_o <= ~a;
		#1;
		d = io_rdata_i;
		v = io_rvalid_i;
	endtask

	// Index always written before the data access
	task automatic reg_write(input logic alt, input logic [7:0] idx, input logic [7:0] d);
		io_write(alt ? ICRB_IDX_ALT : ICRB_IDX_PRI, idx);
		io_write(alt ? ICRB_DAT_ALT : ICRB_DAT_PRI, d);
	endtask

	task automatic reg_read(input logic alt, input logic [7:0] idx, output logic [7:0] d,
				output logic v);
		io_write(alt ? ICRB_IDX_ALT : ICRB_IDX_PRI, idx);
		io_read(alt ? ICRB_DAT_ALT : ICRB_DAT_PRI, d, v);
	endtask

endmodule

`default_nettype wire

// ---- testbench/tb.sv ----
/*
 * Self-checking bench for the configuration register bank.
 * Assumes the host model drives the I/O bus and the bench drives modes.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin errors++; \
	$display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module tb;
	import icrb_pkg::*;

	logic                ref_clk_i;
	logic                rst_b_i;
	logic                por_b_i;
	logic                config_mode_i;
	logic                alt_base_i;
	logic [ICRB_AW-1:0]  io_addr_i;
	logic                io_wr_i;
	logic                io_rd_i;
	logic [ICRB_DW-1:0]  io_wdata_i;
	logic [ICRB_DW-1:0]  io_rdata_o;
	logic                io_rvalid_o;
	logic [ICRB_DW-1:0]  config_index_select_o;
	logic                floppy_power_on_o;
	logic                parallel_power_on_o;
	logic                printer_mode_o;
	logic                primary_serial_power_on_o;
	logic                secondary_serial_power_on_o;
	logic                config_valid_o;
	logic                config_write_lock_o;
	logic                drive_pullup_en_o;
	logic                drive_pins_oe_o;
	logic                alt_ir_en_o;
	logic                extra_irq_en_o;
	int                  errors;
	int                  checks_done;
	logic [7:0]          d;
	logic                v;

	icrb_config_bank u_icrb_config_bank (.*);

	icrb_host_model u_icrb_host_model (
		.ref_clk_i  (ref_clk_i),
		.io_rdata_i (io_rdata_o),
		.io_rvalid_i(io_rvalid_o),
		.io_addr_o  (io_addr_i),
		.io_wr_o    (io_wr_i),
		.io_rd_o    (io_rd_i),
		.io_wdata_o (io_wdata_i)
	);

	initial begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic chk_all(input logic [7:0] r0, input logic [7:0] r1, input logic [7:0] r2);
		for (int i = 0; i < 3; i++) begin
			u_icrb_host_model.reg_read(alt_base_i, 8'(i), d, v);
			`CHK(v, 1'b1)
			`CHK(d, (i == 0) ? r0 : (i == 1) ? r1 : r2)
		end
		`CHK(floppy_power_on_o, r0[3])
		`CHK(config_valid_o, r0[7])
		`CHK(drive_pullup_en_o, ~r0[1])
		`CHK(drive_pins_oe_o, r0[1:0] == 2'b10)
		`CHK(alt_ir_en_o, r0[1:0] == 2'b11)
		`CHK(extra_irq_en_o, r0[1:0] == 2'b11)
		`CHK(parallel_power_on_o, r1[2])
		`CHK(printer_mode_o, r1[3])
		`CHK(config_write_lock_o, ~r1[7])
		`CHK(primary_serial_power_on_o, r2[3])
		`CHK(secondary_serial_power_on_o, r2[7])
	endtask

	task automatic pulse(input bit por);
		@(posedge ref_clk_i);
		if (por) begin
			por_b_i <= 1'b0;
		end else begin
			rst_b_i <= 1'b0;
		end
		@(posedge ref_clk_i);
		por_b_i <= 1'b1;
		rst_b_i <= 1'b1;
		#1;
	endtask

	task automatic done_test(input string name);
		$display("test %s done, errors so far %0d", name, errors);
	endtask

	task automatic stop_test;
		$display("comparisons %0d, mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Whole sequence needs well under 2000 cycles
	initial begin
		#125000;
		errors++;
		stop_test();
	end

	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial begin
		errors = 0;
		checks_done = 0;
		rst_b_i = 1'b0;
		por_b_i = 1'b0;
		config_mode_i = 1'b1;
		alt_base_i = 1'b0;
		repeat (2) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		por_b_i <= 1'b1;
		chk_all(8'h28, 8'h9C, 8'h88);
		done_test("power_up");
		for (int c = 0; c < 4; c++) begin
			u_icrb_host_model.reg_write(1'b0, 8'h00, 8'hFC | 8'(c));
			chk_all(8'hA8 | 8'(c), 8'h9C, 8'h88);
		end
		u_icrb_host_model.reg_write(1'b0, 8'h00, 8'h00);
		chk_all(8'h20, 8'h9C, 8'h88);
		done_test("reg0");
		u_icrb_host_model.reg_write(1'b0, 8'h01, 8'hF3);
		chk_all(8'h20, 8'h90, 8'h88);
		u_icrb_host_model.reg_write(1'b0, 8'h01, 8'hFF);
		chk_all(8'h20, 8'h9C, 8'h88);
		u_icrb_host_model.reg_write(1'b0, 8'h02, 8'h77);
		chk_all(8'h20, 8'h9C, 8'h00);
		u_icrb_host_model.reg_write(1'b0, 8'h02, 8'hFF);
		chk_all(8'h20, 8'h9C, 8'h88);
		done_test("reg1_reg2");
		u_icrb_host_model.reg_read(1'b0, 8'h05, d, v);
		`CHK(d, 8'h00)
		`CHK(config_index_select_o, 8'h05)
		u_icrb_host_model.io_read(ICRB_IDX_PRI, d, v);
		`CHK(v, 1'b0)
		u_icrb_host_model.reg_write(1'b0, 8'h05, 8'hFF);
		chk_all(8'h20, 8'h9C, 8'h88);
		done_test("index");
		@(posedge ref_clk_i);
		alt_base_i <= 1'b1;
		#1;
		u_icrb_host_model.reg_write(1'b1, 8'h00, 8'h81);
		u_icrb_host_model.io_write(ICRB_DAT_PRI, 8'h00);
		chk_all(8'hA1, 8'h9C, 8'h88);
		@(posedge ref_clk_i);
		alt_base_i <= 1'b0;
		config_mode_i <= 1'b0;
		#1;
		u_icrb_host_model.reg_write(1'b0, 8'h00, 8'h00);
		`CHK(config_index_select_o, 8'h02)
		@(posedge ref_clk_i);
		config_mode_i <= 1'b1;
		chk_all(8'hA1, 8'h9C, 8'h88);
		done_test("alt_base_and_mode");
		u_icrb_host_model.reg_write(1'b0, 8'h01, 8'h1C);
		`CHK(config_write_lock_o, 1'b1)
		u_icrb_host_model.reg_write(1'b0, 8'h00, 8'h00);
		u_icrb_host_model.reg_read(1'b0, 8'h00, d, v);
		`CHK(d, 8'h00)
		u_icrb_host_model.io_write(ICRB_IDX_PRI, 8'h02);
		pulse(1'b0);
		`CHK(config_write_lock_o, 1'b0)
		`CHK(config_index_select_o, 8'h02)
		chk_all(8'hA1, 8'h9C, 8'h88);
		done_test("lock");
		u_icrb_host_model.reg_write(1'b0, 8'h02, 8'h00);
		pulse(1'b1);
		`CHK(config_index_select_o, 8'h00)
		chk_all(8'h28, 8'h9C, 8'h88);
		done_test("power_up_again");
		stop_test();
	end

endmodule

`default_nettype wire
